// [verilog/swmc_watchdog_ctrl.sv]
// Purpose: Mode-control register with serial watchdog and fault readback.
// Assumes: Link pins are asynchronous and slow against the 20 MHz clock.
// Notes: Data is taken on falling serial clock; output shifts after it.
//
// Functional notes
// RQ1: A 16-bit mode-control word is written and read back over the link.
// RQ2: Word has timeout, enable, readback, alarm, ADC, ref, loop, reserved.
// RQ3: Codes 0-7 give 50, 100, 500 ms, 1, 2, 3, 4, 5 s; 1 s after reset.
// RQ4: Writes and no-operations restart the watchdog, one needed each period.
// RQ5: A readback bit decides if the fault word shifts out on each write.
// RQ6: The enable bit is set after reset; a cleared bit suppresses timeouts.
// RQ7: Readback bit 0 shifts the fault word out, bit 1 does not.
// RQ8: A timeout always sets the serial fault flag and the fault pin.
// RQ9: Alarm bit 0 forces alarm current on timeout; bit 1 does not.
// RQ10: Command 0x09 changes no register and ignores its data.

`timescale 1ns/100ps
`default_nettype none

module swmc_watchdog_ctrl #(
  parameter int MS_CYCLES = swmc_pkg::MS_CYCLES
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic sync_n_i,
  input wire logic sclk_i,
  input wire logic sdin_i,
  output logic serial_data_out_o,
  output logic fault_o,
  output logic alarm_force_o,
  output logic [15:0] mode_control_o
);

  localparam int PRE_W = $clog2(MS_CYCLES + 1);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(MS_CYCLES - 1);

  // ==========================================================
  // Pin synchronisers
  // ==========================================================
  logic sync_s1_q, sync_s2_q, sync_s3_q;
  logic sclk_s1_q, sclk_s2_q, sclk_s3_q;
  logic sdin_s1_q, sdin_s2_q;

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      sync_s1_q <= 1'b1;
      sync_s2_q <= 1'b1;
      sync_s3_q <= 1'b1;
      sclk_s1_q <= 1'b1;
      sclk_s2_q <= 1'b1;
      sclk_s3_q <= 1'b1;
      sdin_s1_q <= 1'b0;
      sdin_s2_q <= 1'b0;
    end else begin
      sync_s1_q <= sync_n_i;
      sync_s2_q <= sync_s1_q;
      sync_s3_q <= sync_s2_q;
      sclk_s1_q <= sclk_i;
      sclk_s2_q <= sclk_s1_q;
      sclk_s3_q <= sclk_s2_q;
      sdin_s1_q <= sdin_i;
      sdin_s2_q <= sdin_s1_q;
    end
  end

  logic frame_start, sync_rise, sclk_fall;
  assign frame_start = sync_s3_q & ~sync_s2_q;
  assign sync_rise = ~sync_s3_q & sync_s2_q;
  assign sclk_fall = sclk_s3_q & ~sclk_s2_q;

  // ==========================================================
  // Serial frame engine
  // ==========================================================
  swmc_pkg::swmc_state_t state_q, state_d;
  logic [4:0] bit_cnt_q, bit_cnt_d;
  logic [23:0] in_sr_q, in_sr_d;
  logic [23:0] out_sr_q, out_sr_d;
  logic [7:0] pend_q, pend_d;
  logic [15:0] mode_q, mode_d;
  logic fault_q, fault_d;
  logic fault_clr, frame_ok;
  logic [7:0] cmd;
  logic [15:0] fault_word;

  assign cmd = in_sr_q[23:16];
  assign fault_word = 16'(fault_q) << swmc_pkg::FLT_SERIAL_BIT;
  // Short or long frames are dropped whole, so a glitch never writes
  assign frame_ok = (state_q == swmc_pkg::SWMC_SHIFT) && sync_rise &&
                    (bit_cnt_q == swmc_pkg::FRAME_BITS);

  always_comb begin
    state_d = state_q;
    bit_cnt_d = bit_cnt_q;
    in_sr_d = in_sr_q;
    out_sr_d = out_sr_q;
    pend_d = pend_q;
    fault_clr = 1'b0;
    case (state_q)
      swmc_pkg::SWMC_IDLE: begin
        if (frame_start) begin
          state_d = swmc_pkg::SWMC_SHIFT;
          bit_cnt_d = 5'h00;
          pend_d = swmc_pkg::CMD_NONE;
          // A pending read answers first; else automatic fault readback
          if (pend_q == swmc_pkg::CMD_RD_CTRL) begin
            out_sr_d = {swmc_pkg::CMD_RD_CTRL, mode_q}; // RQ1
          end else if (pend_q == swmc_pkg::CMD_RD_FAULT) begin
            out_sr_d = {swmc_pkg::CMD_RD_FAULT, fault_word};
            fault_clr = 1'b1;
          end else if (!mode_q[swmc_pkg::AUTO_RB_DIS_BIT]) begin
            out_sr_d = {swmc_pkg::CMD_NONE, fault_word}; // RQ5
            fault_clr = 1'b1;
          end else begin
            out_sr_d = 24'h000000; // RQ7
          end
        end
      end
      swmc_pkg::SWMC_SHIFT: begin
        if (sync_s2_q) begin
          state_d = swmc_pkg::SWMC_IDLE;
          out_sr_d = 24'h000000;
          if (frame_ok && (cmd == swmc_pkg::CMD_RD_CTRL ||
                           cmd == swmc_pkg::CMD_RD_FAULT)) begin
            pend_d = cmd;
          end
        end else if (sclk_fall) begin
          in_sr_d = {in_sr_q[22:0], sdin_s2_q};
          out_sr_d = {out_sr_q[22:0], 1'b0};
          if (bit_cnt_q != swmc_pkg::BIT_CNT_MAX) begin
            bit_cnt_d = bit_cnt_q + 5'h01;
          end
        end
      end
      default: state_d = swmc_pkg::SWMC_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      state_q <= swmc_pkg::SWMC_IDLE;
      bit_cnt_q <= 5'h00;
      in_sr_q <= 24'h000000;
      out_sr_q <= 24'h000000;
      pend_q <= swmc_pkg::CMD_NONE;
    end else begin
      state_q <= state_d;
      bit_cnt_q <= bit_cnt_d;
      in_sr_q <= in_sr_d;
      out_sr_q <= out_sr_d;
      pend_q <= pend_d;
    end
  end

  // ==========================================================
  // Mode register and watchdog
  // ==========================================================
  logic [PRE_W-1:0] pre_cnt_q, pre_cnt_d;
  logic [12:0] ms_cnt_q, ms_cnt_d;
  logic [12:0] period_ms;
  logic alarm_q, alarm_d;
  logic restart, ms_tick, timeout, wdt_en;

  assign wdt_en = mode_q[swmc_pkg::WDT_EN_BIT];
  assign period_ms = swmc_pkg::swmc_period_ms(
      mode_q[swmc_pkg::TSEL_MSB:swmc_pkg::TSEL_LSB]);
  // Any write command or no-operation counts; reads do not feed the dog
  assign restart = frame_ok && (cmd >= swmc_pkg::CMD_WR_FIRST) &&
                   (cmd <= swmc_pkg::CMD_NOP); // RQ4 RQ10
  assign ms_tick = (pre_cnt_q == PRE_LAST);
  // A restart in the expiry cycle still counts as in time
  assign timeout = wdt_en && ms_tick && !restart &&
                   (ms_cnt_q == period_ms - 13'h0001); // RQ3

  always_comb begin
    mode_d = mode_q;
    pre_cnt_d = pre_cnt_q;
    ms_cnt_d = ms_cnt_q;
    if (frame_ok && cmd == swmc_pkg::CMD_WR_CTRL) begin
      mode_d = in_sr_q[15:0] & swmc_pkg::MODE_WR_MASK; // RQ2
    end
    if (restart || !wdt_en || timeout) begin
      pre_cnt_d = '0; // RQ6
      ms_cnt_d = 13'h0000;
    end else if (ms_tick) begin
      pre_cnt_d = '0;
      ms_cnt_d = ms_cnt_q + 13'h0001;
    end else begin
      pre_cnt_d = pre_cnt_q + PRE_W'(1);
    end
    // Set wins over the readback clear
    fault_d = timeout | (fault_q & ~fault_clr); // RQ8
    alarm_d = fault_d & ~mode_d[swmc_pkg::ALARM_DIS_BIT]; // RQ9
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      mode_q <= swmc_pkg::MODE_RESET;
      pre_cnt_q <= '0;
      ms_cnt_q <= 13'h0000;
      fault_q <= 1'b0;
      alarm_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      pre_cnt_q <= pre_cnt_d;
      ms_cnt_q <= ms_cnt_d;
      fault_q <= fault_d;
      alarm_q <= alarm_d;
    end
  end

  assign serial_data_out_o = out_sr_q[23];
  assign fault_o = fault_q;
  assign alarm_force_o = alarm_q;
  assign mode_control_o = mode_q;

  // ==========================================================
  // Checks
  // ==========================================================
  mode_write_a: assert property ( // RQ1
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    frame_ok && cmd == swmc_pkg::CMD_WR_CTRL |=>
      mode_q == ($past(in_sr_q[15:0]) & swmc_pkg::MODE_WR_MASK))
    else $error("mode word not written");

  reserved_zero_a: assert property ( // RQ2
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    mode_q[4:0] == 5'h00)
    else $error("reserved mode bits set");

  reset_mode_a: assert property (@(posedge clk_sys_i) // RQ3
    sys_rst_i |=> mode_q == swmc_pkg::MODE_RESET)
    else $error("mode reset value wrong");

  wdt_restart_a: assert property ( // RQ4
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    restart |=> ms_cnt_q == 13'h0000 && pre_cnt_q == '0 && !$rose(fault_q))
    else $error("watchdog not restarted");

  auto_readback_a: assert property ( // RQ5
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    state_q == swmc_pkg::SWMC_IDLE && frame_start &&
    pend_q == swmc_pkg::CMD_NONE && !mode_q[swmc_pkg::AUTO_RB_DIS_BIT] |=>
      out_sr_q == {swmc_pkg::CMD_NONE, $past(fault_word)})
    else $error("fault word not loaded");

  wdt_off_a: assert property ( // RQ6
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    !wdt_en |=> !fault_q || $past(fault_q))
    else $error("timeout while disabled");

  no_readback_a: assert property ( // RQ7
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    state_q == swmc_pkg::SWMC_IDLE && frame_start &&
    pend_q == swmc_pkg::CMD_NONE && mode_q[swmc_pkg::AUTO_RB_DIS_BIT] |=>
      out_sr_q == 24'h000000 && !$fell(fault_q))
    else $error("fault word shifted while disabled");

  fault_set_a: assert property ( // RQ8
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    timeout |=> fault_o && ms_cnt_q == 13'h0000)
    else $error("timeout did not flag fault");

  alarm_sel_a: assert property ( // RQ9
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    alarm_force_o == (fault_q && !mode_q[swmc_pkg::ALARM_DIS_BIT]))
    else $error("alarm force mismatch");

  nop_keep_a: assert property ( // RQ10
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    frame_ok && cmd == swmc_pkg::CMD_NOP |-> restart ##1 $stable(mode_q))
    else $error("no-operation changed mode");

endmodule // swmc_watchdog_ctrl

`default_nettype wire

// [include/swmc_pkg.sv]
// Purpose: Constants and types for the serial watchdog and mode control.
// Assumes: 20 MHz system clock; 24-bit frames, command byte first.
// Notes: Field positions follow the mode-control word layout.

`default_nettype none

package swmc_pkg;

  // ==========================================================
  // Timing
  // ==========================================================
  localparam int CLK_FREQ_HZ = 20_000_000;
  localparam int MS_PER_S = 1000;
  localparam int MS_CYCLES = CLK_FREQ_HZ / MS_PER_S;

  localparam logic [12:0] WDT_MS_0 = 13'h0032;  // 50 ms
  localparam logic [12:0] WDT_MS_1 = 13'h0064;  // 100 ms
  localparam logic [12:0] WDT_MS_2 = 13'h01F4;  // 500 ms
  localparam logic [12:0] WDT_MS_3 = 13'h03E8;  // 1 s
  localparam logic [12:0] WDT_MS_4 = 13'h07D0;  // 2 s
  localparam logic [12:0] WDT_MS_5 = 13'h0BB8;  // 3 s
  localparam logic [12:0] WDT_MS_6 = 13'h0FA0;  // 4 s
  localparam logic [12:0] WDT_MS_7 = 13'h1388;  // 5 s

  // ==========================================================
  // Frame and commands
  // ==========================================================
  localparam logic [4:0] FRAME_BITS = 5'h18;
  localparam logic [4:0] BIT_CNT_MAX = 5'h1F;
  localparam logic [7:0] CMD_WR_FIRST = 8'h01;
  localparam logic [7:0] CMD_WR_CTRL = 8'h02;
  localparam logic [7:0] CMD_NOP = 8'h09;
  localparam logic [7:0] CMD_RD_CTRL = 8'h82;
  localparam logic [7:0] CMD_RD_FAULT = 8'h85;
  localparam logic [7:0] CMD_NONE = 8'h00;

  // ==========================================================
  // Mode-control word
  // ==========================================================
  localparam int TSEL_MSB = 15;
  localparam int TSEL_LSB = 13;
  localparam int WDT_EN_BIT = 12;
  localparam int AUTO_RB_DIS_BIT = 11;
  localparam int ALARM_DIS_BIT = 10;
  localparam int MIN_LOOP_BIT = 9;
  localparam int ADC_SEL_BIT = 8;
  localparam int ADC_EN_BIT = 7;
  localparam int REF_PD_BIT = 6;
  localparam int LOOP_ALERT_BIT = 5;
  localparam logic [15:0] MODE_WR_MASK = 16'hFFE0;
  localparam logic [15:0] MODE_RESET = 16'h7000;

  // Fault register
  localparam int FLT_SERIAL_BIT = 15;

  typedef enum logic {
    SWMC_IDLE = 1'b0,
    SWMC_SHIFT = 1'b1
  } swmc_state_t;

  function automatic logic [12:0] swmc_period_ms(input logic [2:0] sel);
    case (sel)
      3'h0: swmc_period_ms = WDT_MS_0;
      3'h1: swmc_period_ms = WDT_MS_1;
      3'h2: swmc_period_ms = WDT_MS_2;
      3'h3: swmc_period_ms = WDT_MS_3;
      3'h4: swmc_period_ms = WDT_MS_4;
      3'h5: swmc_period_ms = WDT_MS_5;
      3'h6: swmc_period_ms = WDT_MS_6;
      default: swmc_period_ms = WDT_MS_7;
    endcase
  endfunction

endpackage

`default_nettype wire

// [tb/swmc_host_model.sv]
// Purpose: Host model driving the three-wire link of the block.
// Assumes: Pins change on falling system clock; link clock 400 ns.
// Notes: Data line flips between frames so a stale bit never matches.

`timescale 1ns/100ps
`default_nettype none

module swmc_host_model (
  input wire logic clk_sys_i,
  input wire logic serial_data_out_i,
  output logic sync_n_o,
  output logic sclk_o,
  output logic sdin_o
);
  // ==========================================================
  // Frames
  // ==========================================================
  initial begin
    sync_n_o = 1'b1;
    sclk_o = 1'b1;
    sdin_o = 1'b0;
  end

  // Short bit counts build frames the device must refuse
  task automatic xfer(input logic [23:0] tx, input int nbits,
                      output logic [23:0] rx);
    rx = 24'h000000;
    @(negedge clk_sys_i) sync_n_o = 1'b0;
    repeat (8) @(negedge clk_sys_i);
    for (int i = 23; i > 23 - nbits; i--) begin
      sdin_o = tx[i];
      repeat (4) @(negedge clk_sys_i);
      rx[i] = serial_data_out_i;
      sclk_o = 1'b0;
      repeat (4) @(negedge clk_sys_i);
      sclk_o = 1'b1;
    end
    repeat (4) @(negedge clk_sys_i);
    sync_n_o = 1'b1;
    sdin_o = ~sdin_o;
    repeat (8) @(negedge clk_sys_i);
  endtask
endmodule // swmc_host_model

`default_nettype wire

// [tb/swmc_watchdog_ctrl_tb_top.sv]
// Purpose: Self-checking bench for the watchdog and mode register.
// Assumes: One millisecond shortened to two system clocks.
// Notes: Expected periods come from the timeout table below.

`timescale 1ns/100ps
`default_nettype none

module swmc_watchdog_ctrl_tb_top;
  localparam int MSC = 2;
  logic clk_sys_i, sys_rst_i, sync_n, sclk, sdin, serial_data_out, fault, alarm;
  logic [15:0] mode;
  logic [23:0] rx;
  int err_total = 0;
  int total_checks = 0;
  int n;
  int per_ms [8] = '{50, 100, 500, 1000, 2000, 3000, 4000, 5000};
  logic [15:0] rows [4][2] = '{'{16'h8800, 16'h8800},
    '{16'hEC1F, 16'hEC00}, '{16'h6BFF, 16'h6BE0}, '{16'h0000, 16'h0000}};

  swmc_watchdog_ctrl #(.MS_CYCLES(MSC)) i_swmc_watchdog_ctrl (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .sync_n_i(sync_n),
    .sclk_i(sclk), .sdin_i(sdin), .serial_data_out_o(serial_data_out),
    .fault_o(fault), .alarm_force_o(alarm), .mode_control_o(mode));

  swmc_host_model i_swmc_host_model (.clk_sys_i(clk_sys_i),
    .serial_data_out_i(serial_data_out), .sync_n_o(sync_n), .sclk_o(sclk),
    .sdin_o(sdin));

  initial begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end

  // ==========================================================
  // Helpers
  // ==========================================================
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic xf(input logic [7:0] cmd, input logic [15:0] d);
    i_swmc_host_model.xfer({cmd, d}, 24, rx);
  endtask

  task automatic rst();
    sys_rst_i = 1'b1;
    repeat (3) @(negedge clk_sys_i);
    chk({serial_data_out, fault, alarm, mode}, 24'h007000);
    sys_rst_i = 1'b0;
  endtask

  // Counts from the call, a few clocks after the last restart; slack covers that and prescaler phase
  task automatic tmo(input int p, input logic alm);
    n = 0;
    while (fault !== 1'b1) begin
      @(negedge clk_sys_i);
      n++;
      if (n > 11000) begin
        err_total++;
        tally_and_finish();
      end
    end
    chk(24'(n >= p * MSC - 8 && n <= p * MSC + 4), 24'h1);
    chk({fault, alarm}, {1'b1, alm});
  endtask

  task automatic clr();
    xf(8'h02, 16'h0800);
    chk(rx, 24'h000000);
    chk(fault, 1'b1);
    xf(8'h85, 16'h0000);
    xf(8'h09, 16'h0000);
    chk(rx, 24'h858000);
    chk({fault, alarm}, 2'b00);
  endtask

  // ==========================================================
  // Sequence
  // ==========================================================
  initial begin
    sys_rst_i = 1'b1;
    rst();
    foreach (rows[i]) begin
      xf(8'h02, rows[i][0]);
      chk(mode, rows[i][1]);
      xf(8'h82, 16'h0000);
      xf(8'h09, 16'h0000);
      chk(rx, {8'h82, rows[i][1]});
    end
    rst();
    tmo(1000, 1'b1);
    xf(8'h09, 16'h0000);
    chk(rx, 24'h008000);
    xf(8'h09, 16'h0000);
    chk(rx | 24'(fault), 24'h000000);
    // Full no-ops keep it alive; cut frames must not
    xf(8'h02, 16'h5800);
    repeat (6) begin
      xf(8'h09, 16'hFFFF);
      chk({fault, mode}, 17'h05800);
    end
    repeat (6) i_swmc_host_model.xfer(24'h09FFFF, 23, rx);
    chk(fault, 1'b1);
    clr();
    repeat (2200) @(negedge clk_sys_i);
    chk(fault, 1'b0);
    for (int c = 0; c < 8; c++) begin
      xf(8'h02, {c[2:0], 2'b11, c[0], 10'h000});
      tmo(per_ms[c], ~c[0]);
      clr();
    end
    tally_and_finish();
  end
endmodule // swmc_watchdog_ctrl_tb_top

`default_nettype wire
